// ---- tb_top.sv ----
// Self-checking testbench for the timer count and channel control block
`timescale 1ns/10ps
`default_nettype none

module tb_top
    import tcc_pkg::*;
;
    logic clk, rst_n, testMode, waitMode, freezeMode, timerTick, chan7OverrideEvent, accumAccess;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, overflowEvent, irq;
    logic overflowFlagClear, accumFlagClear, div64Tick, accumRun, clrSeen;
    logic [7:0] s_axi_awaddr, s_axi_araddr, captureCompareSelect, chan7OverrideMask;
    logic [7:0] chan7OverrideData, compareMatch, forceCompare, chanRead, chanWrite, pinIn;
    logic [7:0] pinOut, pinOe, captureEvent, channelFlagClear, p;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, lastResp;
    logic [15:0] freeRunningCount;
    logic [19:0] seen;
    int errors, testsRun;

    tcc_timer_core uut (.*);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Sticky record of output pulses, so short pulses are never missed
    always @(posedge clk) seen <= (clrSeen || !rst_n) ? 20'h0 : seen | {div64Tick,
        overflowEvent, accumFlagClear, overflowFlagClear, channelFlagClear, captureEvent};

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        testsRun++;
        if (s !== e) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        lastResp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        lastResp = s_axi_rresp;
        chk(s_axi_rdata, e);
        s_axi_rready <= 1'b0;
    endtask : rdChk

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            timerTick <= 1'b1;
            @(posedge clk);
            timerTick <= 1'b0;
        end
        repeat (3) @(posedge clk);
    endtask : tick

    task automatic clr();
        @(posedge clk);
        clrSeen <= 1'b1;
        @(posedge clk);
        clrSeen <= 1'b0;
    endtask : clr

    // Load all ones in test mode, then one tick wraps the count
    task automatic ovf();
        @(posedge clk);
        testMode <= 1'b1;
        wr({IDX_COUNT_WORD, 2'b00}, 32'h0000ffff);
        @(posedge clk);
        testMode <= 1'b0;
        tick(1);
    endtask : ovf

    task automatic acc();
        @(posedge clk);
        chanRead <= 8'h01;
        chanWrite <= 8'h10;
        accumAccess <= 1'b1;
        @(posedge clk);
        chanRead <= 8'h00;
        chanWrite <= 8'h00;
        accumAccess <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : acc

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", testsRun, errors);
        if (errors == 0 && testsRun > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        conclude();
    end

    initial begin
        rst_n = 1'b0;
        {testMode, waitMode, freezeMode, timerTick, chan7OverrideEvent, accumAccess} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, clrSeen} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, compareMatch, forceCompare} = '0;
        {chanRead, chanWrite, pinIn, chan7OverrideMask} = '0;
        s_axi_wstrb = 4'hf;
        captureCompareSelect = 8'hff;
        chan7OverrideData = 8'h04;
        errors = 0;
        testsRun = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        // Upper bits written as ones must read back as zero
        for (int i = 7; i <= 11; i++) begin
            p = 8'h5a ^ 8'(i);
            rdChk({6'(i), 2'b00}, 32'h0);
            wr({6'(i), 2'b00}, 32'hffffff00 | 32'(p));
            rdChk({6'(i), 2'b00}, 32'(p));
            wr({6'(i), 2'b00}, 32'h0);
        end
        rdChk({IDX_CTRL_ONE, 2'b00}, 32'h0);
        wr({IDX_CTRL_ONE, 2'b00}, 32'hf0);
        rdChk({IDX_CTRL_ONE, 2'b00}, 32'hf0);
        wr(8'h3c, 32'h1);
        chk(32'(lastResp), 32'(RESP_SLVERR));
        rdChk(8'h3c, 32'h0);
        wr({IDX_CTRL_ONE, 2'b00}, 32'h80);
        // Channels 3..0 set to high, low, toggle, disconnected
        wr({IDX_CMP_LOWER, 2'b00}, 32'he4);
        repeat (3) @(posedge clk);
        chk(32'(pinOe), 32'h0e);
        @(posedge clk);
        compareMatch <= 8'h0f;
        @(posedge clk);
        compareMatch <= 8'h00;
        repeat (3) @(posedge clk);
        chk(32'(pinOut & 8'h0e), 32'h0a);
        forceCompare <= 8'h02;
        @(posedge clk);
        forceCompare <= 8'h00;
        repeat (3) @(posedge clk);
        chk(32'(pinOut & 8'h0e), 32'h08);
        rdChk({IDX_IRQ_STATUS, 2'b00}, 32'h4);
        tick(5);
        rdChk({IDX_COUNT_WORD, 2'b00}, 32'h5);
        chk(32'(freeRunningCount), 32'h5);
        rdChk({IDX_COUNT_HIGH, 2'b00}, 32'h0);
        wr({IDX_COUNT_LOW, 2'b00}, 32'haa);
        rdChk({IDX_COUNT_LOW, 2'b00}, 32'h5);
        wr({IDX_CTRL_ONE, 2'b00}, 32'h0);
        clr();
        tick(3);
        repeat (70) @(posedge clk);
        rdChk({IDX_COUNT_WORD, 2'b00}, 32'h5);
        chk(32'(seen[19]), 32'h0);
        wr({IDX_CTRL_ONE, 2'b00}, 32'h80);
        clr();
        repeat (70) @(posedge clk);
        chk(32'(seen[19]), 32'h1);
        wr({IDX_CTRL_ONE, 2'b00}, 32'hc0);
        waitMode <= 1'b1;
        tick(2);
        rdChk({IDX_COUNT_WORD, 2'b00}, 32'h5);
        chk(32'(accumRun), 32'h0);
        waitMode <= 1'b0;
        wr({IDX_CTRL_ONE, 2'b00}, 32'ha0);
        freezeMode <= 1'b1;
        tick(2);
        rdChk({IDX_COUNT_WORD, 2'b00}, 32'h5);
        chk(32'(accumRun), 32'h1);
        freezeMode <= 1'b0;
        wr({IDX_CTRL_ONE, 2'b00}, 32'h80);
        wr({IDX_TOGGLE_SEL, 2'b00}, 32'h02);
        clr();
        ovf();
        rdChk({IDX_COUNT_WORD, 2'b00}, 32'h0);
        chk(32'(seen[18]), 32'h1);
        chk(32'(pinOut & 8'h0e), 32'h0a);
        chk(32'(irq), 32'h1);
        rdChk({IDX_IRQ_STATUS, 2'b00}, 32'h1);
        @(posedge clk);
        chk(32'(irq), 32'h0);
        chk(32'(seen[16]), 32'h0);
        // Masked overflow: status set, line stays low
        wr({IDX_IRQ_MASK, 2'b00}, 32'h1);
        ovf();
        chk(32'(irq), 32'h0);
        rdChk({IDX_IRQ_STATUS, 2'b00}, 32'h1);
        chan7OverrideMask <= 8'h04;
        @(posedge clk);
        chan7OverrideEvent <= 1'b1;
        @(posedge clk);
        chan7OverrideEvent <= 1'b0;
        repeat (3) @(posedge clk);
        chk(32'(pinOut & 8'h0e), 32'h0c);
        chan7OverrideMask <= 8'h00;
        compareMatch <= 8'h04;
        @(posedge clk);
        compareMatch <= 8'h00;
        repeat (3) @(posedge clk);
        chk(32'(pinOut & 8'h0e), 32'h08);
        captureCompareSelect <= 8'hf0;
        clr();
        acc();
        chk(32'(seen[17:8]), 32'h0);
        chk(32'(pinOe[7]), 32'h0);
        wr({IDX_CTRL_ONE, 2'b00}, 32'h90);
        clr();
        acc();
        chk(32'(seen[17:8]), 32'h211);
        clr();
        rdChk({IDX_COUNT_LOW, 2'b00}, 32'h0);
        repeat (2) @(posedge clk);
        chk(32'(seen[16]), 32'h1);
        // Channels 3..0: off, both, falling, rising
        wr({IDX_CTRL_ONE, 2'b00}, 32'h80);
        wr({IDX_EDGE_LOWER, 2'b00}, 32'h39);
        clr();
        pinIn <= 8'h0f;
        repeat (6) @(posedge clk);
        chk(32'(seen[7:0] & 8'h0f), 32'h05);
        clr();
        pinIn <= 8'h00;
        repeat (6) @(posedge clk);
        chk(32'(seen[7:0] & 8'h0f), 32'h06);
        conclude();
    end
endmodule : tb_top

`default_nettype wire

// ---- tcc_core_checker_properties.sv ----
// Port-level assertions for the timer count and channel control block
`timescale 1ns/10ps
`default_nettype none

module tcc_core_checker
    import tcc_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              testMode,
    input wire logic              timerTick,
    input wire logic              freezeMode,
    input wire logic [NUM_CH-1:0] chanRead,
    input wire logic [NUM_CH-1:0] chanWrite,
    input wire logic              accumAccess,
    input wire logic [CNT_W-1:0]  freeRunningCount,
    input wire logic              overflowEvent,
    input wire logic [NUM_CH-1:0] channelFlagClear,
    input wire logic              accumFlagClear,
    input wire logic              div64Tick,
    input wire logic              accumRun
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Wrap from all ones to zero
    sequence s_wrap;
        freeRunningCount == COUNT_MAX ##1 freeRunningCount == RST_COUNT;
    endsequence
    // Two sampled cycles with the timer inactive
    sequence s_idle2;
        !accumRun ##1 !accumRun;
    endsequence

    property p_count_step;
        timerTick && accumRun && !freezeMode && !testMode |=>
            freeRunningCount == $past(freeRunningCount) + 16'h0001;
    endproperty
    property p_count_hold;
        !testMode && !timerTick |=> $stable(freeRunningCount);
    endproperty
    property p_halt_hold;
        !accumRun && !testMode |=> $stable(freeRunningCount);
    endproperty
    property p_wrap_event;
        s_wrap |-> ##[0:1] overflowEvent;
    endproperty
    property p_event_pulse;
        overflowEvent |=> !overflowEvent;
    endproperty
    property p_div_off;
        s_idle2 |-> !div64Tick;
    endproperty
    property p_div_gap;
        div64Tick |=> !div64Tick [*8];
    endproperty
    property p_chan_clear;
        channelFlagClear != 8'h00 |->
            (channelFlagClear & ~$past(chanRead | chanWrite)) == 8'h00;
    endproperty
    property p_accum_clear;
        accumFlagClear |-> $past(accumAccess);
    endproperty

    a_count_step: assert property (p_count_step) else $error("count step wrong");
    a_count_hold: assert property (p_count_hold) else $error("count moved");
    a_halt_hold: assert property (p_halt_hold) else $error("count ran inactive");
    a_wrap_event: assert property (p_wrap_event) else $error("no overflow event");
    a_event_pulse: assert property (p_event_pulse) else $error("long overflow event");
    a_div_off: assert property (p_div_off) else $error("div64 tick inactive");
    a_div_gap: assert property (p_div_gap) else $error("div64 ticks too close");
    a_chan_clear: assert property (p_chan_clear) else $error("stray channel clear");
    a_accum_clear: assert property (p_accum_clear) else $error("stray accum clear");
endmodule : tcc_core_checker

bind tcc_timer_core tcc_core_checker u_chk (.*);

`default_nettype wire

// ---- tcc_pkg.sv ----
// Constants and types shared by the timer count and channel control block
package tcc_pkg;
    localparam int NUM_CH = 8;
    localparam int CNT_W  = 16;
    localparam int ST_W   = 3;

    // Register indexes; byte address is four times the index
    localparam logic [5:0] IDX_COUNT_HIGH = 6'h04;
    localparam logic [5:0] IDX_COUNT_LOW  = 6'h05;
    localparam logic [5:0] IDX_CTRL_ONE   = 6'h06;
    localparam logic [5:0] IDX_TOGGLE_SEL = 6'h07;
    localparam logic [5:0] IDX_CMP_UPPER  = 6'h08;
    localparam logic [5:0] IDX_CMP_LOWER  = 6'h09;
    localparam logic [5:0] IDX_EDGE_UPPER = 6'h0a;
    localparam logic [5:0] IDX_EDGE_LOWER = 6'h0b;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h30;
    localparam logic [5:0] IDX_IRQ_MASK   = 6'h31;
    localparam logic [5:0] IDX_COUNT_WORD = 6'h32;

    // Field positions in system_control_one
    localparam int BIT_TIMER_ON    = 7;
    localparam int BIT_HALT_WAIT   = 6;
    localparam int BIT_HALT_FREEZE = 5;
    localparam int BIT_FAST_CLEAR  = 4;

    // Field positions in the interrupt status and mask
    localparam int ST_OVERFLOW = 0;
    localparam int ST_CAPTURE  = 1;
    localparam int ST_COMPARE  = 2;

    // Values after reset
    localparam logic [7:0]      RST_BYTE  = 8'h00;
    localparam logic [CNT_W-1:0] RST_COUNT = 16'h0000;
    localparam logic [ST_W-1:0]  RST_ST    = 3'h0;

    // Divide-by-64 reference: 64 bus cycles per tick
    localparam int         DIV64_CYCLES = 64;
    localparam logic [5:0] DIV64_LAST   = 6'(DIV64_CYCLES - 1);

    localparam logic [CNT_W-1:0] COUNT_MAX = 16'hffff;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic timerOn;
        logic haltInWait;
        logic haltInFreeze;
        logic fastFlagClear;
    } tcc_ctrl_s;
endpackage : tcc_pkg

// ---- tcc_timer_core.sv ----
// Free-running count, global control and per-channel pin control of the timer
`timescale 1ns/10ps
`default_nettype none

module tcc_timer_core
    import tcc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    output logic [1:0]             s_axi_bresp,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    input  wire logic [7:0]        s_axi_araddr,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    input  wire logic              testMode,
    input  wire logic              waitMode,
    input  wire logic              freezeMode,
    input  wire logic              timerTick,
    input  wire logic [NUM_CH-1:0] captureCompareSelect,
    input  wire logic [NUM_CH-1:0] chan7OverrideMask,
    input  wire logic [NUM_CH-1:0] chan7OverrideData,
    input  wire logic              chan7OverrideEvent,
    input  wire logic [NUM_CH-1:0] compareMatch,
    input  wire logic [NUM_CH-1:0] forceCompare,
    input  wire logic [NUM_CH-1:0] chanRead,
    input  wire logic [NUM_CH-1:0] chanWrite,
    input  wire logic              accumAccess,
    input  wire logic [NUM_CH-1:0] pinIn,
    output logic [NUM_CH-1:0]      pinOut,
    output logic [NUM_CH-1:0]      pinOe,
    output logic [CNT_W-1:0]       freeRunningCount,
    output logic                   overflowEvent,
    output logic [NUM_CH-1:0]      captureEvent,
    output logic [NUM_CH-1:0]      channelFlagClear,
    output logic                   overflowFlagClear,
    output logic                   accumFlagClear,
    output logic                   div64Tick,
    output logic                   accumRun,
    output logic                   irq
);

    tcc_ctrl_s                ctrl;
    logic [7:0]               toggleSel;
    logic [2*NUM_CH-1:0]      cmpAction;
    logic [2*NUM_CH-1:0]      edgeSel;
    logic [ST_W-1:0]          irqStatus;
    logic [ST_W-1:0]          irqMask;
    logic [CNT_W-1:0]         count;
    logic                     awHeld;
    logic                     wHeld;
    logic [5:0]               awIdx;
    logic [31:0]              wData;
    logic [3:0]               wStrb;
    logic                     wrFire;
    logic                     rdFire;
    logic [5:0]               arIdx;
    logic [31:0]              next_rdata;
    logic                     rdMapped;
    logic                     wrMapped;
    logic                     timerActive;
    logic                     countRun;
    logic                     countStep;
    logic                     countWrite;
    logic [CNT_W-1:0]         countWrData;
    logic                     countTouch;
    logic [5:0]               divCount;
    logic [NUM_CH-1:0]        pinMeta;
    logic [NUM_CH-1:0]        pinSync;
    logic [NUM_CH-1:0]        pinPrev;
    logic [ST_W-1:0]          stEvents;

    // Bus handshake
    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wrFire = awHeld && wHeld && !s_axi_bvalid;
    assign rdFire = s_axi_arvalid && s_axi_arready;
    assign arIdx  = s_axi_araddr[7:2];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            awHeld <= 1'b0;
            awIdx  <= 6'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awIdx  <= s_axi_awaddr[7:2];
        end else if (wrFire) begin
            awHeld <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wHeld <= 1'b0;
            wData <= 32'h0000_0000;
            wStrb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
        end else if (wrFire) begin
            wHeld <= 1'b0;
        end
    end

    always_comb begin
        case (awIdx)
            IDX_COUNT_HIGH, IDX_COUNT_LOW, IDX_CTRL_ONE, IDX_TOGGLE_SEL,
            IDX_CMP_UPPER, IDX_CMP_LOWER, IDX_EDGE_UPPER, IDX_EDGE_LOWER,
            IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_COUNT_WORD: wrMapped = 1'b1;
            default: wrMapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wrFire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Control registers; only the low byte lane carries them
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl      <= tcc_ctrl_s'(4'h0);
            toggleSel <= RST_BYTE;
            cmpAction <= {RST_BYTE, RST_BYTE};
            edgeSel   <= {RST_BYTE, RST_BYTE};
            irqMask   <= RST_ST;
        end else if (wrFire && wStrb[0]) begin
            case (awIdx)
                IDX_CTRL_ONE: begin
                    ctrl.timerOn       <= wData[BIT_TIMER_ON];
                    ctrl.haltInWait    <= wData[BIT_HALT_WAIT];
                    ctrl.haltInFreeze  <= wData[BIT_HALT_FREEZE];
                    ctrl.fastFlagClear <= wData[BIT_FAST_CLEAR];
                end
                IDX_TOGGLE_SEL: toggleSel           <= wData[7:0];
                IDX_CMP_UPPER:  cmpAction[15:8]     <= wData[7:0];
                IDX_CMP_LOWER:  cmpAction[7:0]      <= wData[7:0];
                IDX_EDGE_UPPER: edgeSel[15:8]       <= wData[7:0];
                IDX_EDGE_LOWER: edgeSel[7:0]        <= wData[7:0];
                IDX_IRQ_MASK:   irqMask             <= wData[ST_W-1:0];
                default: ;
            endcase
        end
    end
    // Count writes land only in test mode
    always_comb begin
        countWrite  = 1'b0;
        countWrData = count;
        if (wrFire && testMode) begin
            case (awIdx)
                IDX_COUNT_HIGH: begin
                    countWrite  = wStrb[0];
                    countWrData = {wData[7:0], count[7:0]};
                end
                IDX_COUNT_LOW: begin
                    countWrite  = wStrb[0];
                    countWrData = {count[15:8], wData[7:0]};
                end
                IDX_COUNT_WORD: begin
                    countWrite  = |wStrb[1:0];
                    countWrData[7:0]  = wStrb[0] ? wData[7:0] : count[7:0];
                    countWrData[15:8] = wStrb[1] ? wData[15:8] : count[15:8];
                end
                default: ;
            endcase
        end
    end
    // Run conditions
    assign timerActive = ctrl.timerOn && !(waitMode && ctrl.haltInWait);
    assign countRun    = timerActive && !(freezeMode && ctrl.haltInFreeze);
    assign countStep   = countRun && timerTick;
    assign accumRun    = timerActive;

    // Tick source is not realigned on a write, so the first period may be short
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= RST_COUNT;
        end else if (countWrite) begin
            count <= countWrData;
        end else if (countStep) begin
            count <= count + 16'h0001;
        end
    end
    assign freeRunningCount = count;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            overflowEvent <= 1'b0;
        end else begin
            overflowEvent <= countStep && !countWrite && (count == COUNT_MAX);
        end
    end
    // Divide-by-64 reference held at zero while inactive
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            divCount  <= 6'h00;
            div64Tick <= 1'b0;
        end else if (!timerActive) begin
            divCount  <= 6'h00;
            div64Tick <= 1'b0;
        end else begin
            divCount  <= divCount + 6'h01;
            div64Tick <= (divCount == DIV64_LAST);
        end
    end

    // Read path; byte halves of the count are sampled separately
    always_comb begin
        next_rdata = 32'h0000_0000;
        rdMapped   = 1'b1;
        case (arIdx)
            IDX_COUNT_HIGH: next_rdata[7:0] = count[15:8];
            IDX_COUNT_LOW:  next_rdata[7:0] = count[7:0];
            IDX_CTRL_ONE: begin
                next_rdata[BIT_TIMER_ON]    = ctrl.timerOn;
                next_rdata[BIT_HALT_WAIT]   = ctrl.haltInWait;
                next_rdata[BIT_HALT_FREEZE] = ctrl.haltInFreeze;
                next_rdata[BIT_FAST_CLEAR]  = ctrl.fastFlagClear;
            end
            IDX_TOGGLE_SEL: next_rdata[7:0] = toggleSel;
            IDX_CMP_UPPER:  next_rdata[7:0] = cmpAction[15:8];
            IDX_CMP_LOWER:  next_rdata[7:0] = cmpAction[7:0];
            IDX_EDGE_UPPER: next_rdata[7:0] = edgeSel[15:8];
            IDX_EDGE_LOWER: next_rdata[7:0] = edgeSel[7:0];
            IDX_IRQ_STATUS: next_rdata[ST_W-1:0] = irqStatus;
            IDX_IRQ_MASK:   next_rdata[ST_W-1:0] = irqMask;
            IDX_COUNT_WORD: next_rdata[15:0] = count;
            default:        rdMapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (rdFire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= rdMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Fast flag clearing; any count access, read or write, counts
    assign countTouch = (rdFire && (arIdx == IDX_COUNT_HIGH || arIdx == IDX_COUNT_LOW
                                    || arIdx == IDX_COUNT_WORD))
                     || (wrFire && (awIdx == IDX_COUNT_HIGH || awIdx == IDX_COUNT_LOW
                                    || awIdx == IDX_COUNT_WORD));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            overflowFlagClear <= 1'b0;
            accumFlagClear    <= 1'b0;
            channelFlagClear  <= 8'h00;
        end else begin
            overflowFlagClear <= ctrl.fastFlagClear && countTouch;
            accumFlagClear    <= ctrl.fastFlagClear && accumAccess;
            channelFlagClear  <= {NUM_CH{ctrl.fastFlagClear}}
                              & ((chanRead & ~captureCompareSelect)
                              | (chanWrite & captureCompareSelect));
        end
    end

    // Pin synchroniser
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pinMeta <= 8'h00;
            pinSync <= 8'h00;
            pinPrev <= 8'h00;
        end else begin
            pinMeta <= pinIn;
            pinSync <= pinMeta;
            pinPrev <= pinSync;
        end
    end

    // Per-channel capture detect and compare pin action
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
        logic       modeBit;
        logic       levelBit;
        logic       edgeLow;
        logic       edgeHigh;
        logic       rise;
        logic       fall;
        logic       next_line;
        assign modeBit  = cmpAction[2*ch+1];
        assign levelBit = cmpAction[2*ch];
        assign edgeLow  = edgeSel[2*ch];
        assign edgeHigh = edgeSel[2*ch+1];
        assign rise     = pinSync[ch] && !pinPrev[ch];
        assign fall     = !pinSync[ch] && pinPrev[ch];
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                captureEvent[ch] <= 1'b0;
            end else begin
                captureEvent[ch] <= !captureCompareSelect[ch] && timerActive
                                 && ((edgeLow && rise) || (edgeHigh && fall));
            end
        end
        // Override first, then overflow toggle, then force or match alike
        always_comb begin
            next_line = pinOut[ch];
            if (chan7OverrideEvent && chan7OverrideMask[ch]) begin
                next_line = chan7OverrideData[ch];
            end else if (overflowEvent && toggleSel[ch]) begin
                next_line = !pinOut[ch];
            end else if (forceCompare[ch] || compareMatch[ch]) begin
                case ({modeBit, levelBit})
                    2'h1:    next_line = !pinOut[ch];
                    2'h2:    next_line = 1'b0;
                    2'h3:    next_line = 1'b1;
                    default: next_line = pinOut[ch];
                endcase
            end
        end
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                pinOut[ch] <= 1'b0;
            end else if (captureCompareSelect[ch]) begin
                pinOut[ch] <= next_line;
            end
        end
        // Mask drives the pin for the override; clear it to hand over
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                pinOe[ch] <= 1'b0;
            end else begin
                pinOe[ch] <= captureCompareSelect[ch]
                          && (modeBit || levelBit || chan7OverrideMask[ch]);
            end
        end
    end

    // Interrupt status; set beats a read clear in the same cycle
    assign stEvents = {|(compareMatch & captureCompareSelect), |captureEvent, overflowEvent};
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irqStatus <= RST_ST;
        end else if (rdFire && arIdx == IDX_IRQ_STATUS) begin
            irqStatus <= stEvents;
        end else begin
            irqStatus <= irqStatus | stEvents;
        end
    end

    // Halted in wait, the timer must not wake the core
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= (|(irqStatus & ~irqMask)) && !(waitMode && ctrl.haltInWait);
        end
    end

endmodule : tcc_timer_core
`default_nettype wire
